// file: rtl/fls_params.svh
// Constants for the fuse, lock and signature readout block
`ifndef FLS_PARAMS_SVH
`define FLS_PARAMS_SVH
`define FLS_ADDR_FUSE_LOW    16'h0000
`define FLS_ADDR_LOCK        16'h0001
`define FLS_ADDR_FUSE_EXT    16'h0002
`define FLS_ADDR_FUSE_HIGH   16'h0003
`define FLS_ADDR_SIG_0       16'h0000
`define FLS_ADDR_CAL         16'h0001
`define FLS_ADDR_SIG_1       16'h0002
`define FLS_ADDR_SIG_2       16'h0004
`define FLS_LOAD_WINDOW      3
`define FLS_STORE_WINDOW     4
`define FLS_CLK_HZ           25000000
`define FLS_WRITE_MIN_US     3700
`define FLS_WRITE_MAX_US     4500
`define FLS_WRITE_CYCLES     ((`FLS_WRITE_MIN_US * (`FLS_CLK_HZ / 1000000)) + 1)
`define FLS_LOCK_UNDEF_MASK  8'hC0
`define FLS_EXT_UNDEF_MASK   8'hF8
`endif

// file: rtl/fls_pkg.sv
// Types for the fuse, lock and signature readout block
package fls_pkg;
    typedef enum logic [1:0] {
        FLS_ARM_NONE,
        FLS_ARM_LOCK,
        FLS_ARM_SIG
    } fls_arm_e;
    typedef enum logic [1:0] {
        FLS_OP_NONE,
        FLS_OP_ERASE,
        FLS_OP_PAGE_WRITE,
        FLS_OP_LOCK_WRITE
    } fls_op_e;
endpackage : fls_pkg

// file: rtl/fls_write_timer.sv
// Flash write duration timer that survives core reset
`include "fls_params.svh"
module fls_write_timer #(
    parameter int unsigned WRITE_CYCLES = `FLS_WRITE_CYCLES
) (
    input  wire logic i_core_clk,
    input  wire logic i_por_n,
    input  wire logic i_start,
    output logic      o_busy
);
    import fls_pkg::*;

    logic [23:0] count_q;

    // Only power-on reset clears the timer so a running write completes
    always_ff @(posedge i_core_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            count_q <= 24'h000000;
        end else if (i_start && count_q == 24'h000000) begin
            count_q <= 24'(WRITE_CYCLES);
        end else if (count_q != 24'h000000) begin
            count_q <= count_q - 24'h000001;
        end
    end

    assign o_busy = (count_q != 24'h000000);
endmodule : fls_write_timer

// file: rtl/fls_readout.sv
// Fuse, lock and signature readout through the self-programming control register
//
// Summary of operation
// - Pointer 0x0001 with lock-set armed: a load within three cycles returns lock byte.
// - Lock-set arming clears after read, after store, or four cycles without either; the load window closes after three.
// - Once disarmed, loads return ordinary flash contents.
// - Lock byte holds boot lock bits 5..2, memory lock bits 1..0, top undefined.
// - Pointer 0x0000 with lock-set armed returns the low fuse byte.
// - Pointer 0x0003 with lock-set armed returns the high fuse byte.
// - Pointer 0x0002 with lock-set armed returns extended fuse byte, three bits at 2..0.
// - Programmed bits read as 0, unprogrammed bits read as 1.
// - Signature-read armed: a load within three cycles returns the selected row byte.
// - Signature arming clears after read or three cycles without load.
// - Identity bytes sit at pointer 0x0000, 0x0002 and 0x0004.
// - Pointer 0x0001 in signature mode returns the oscillator calibration byte.
// - Each flash write lasts between 3.7 ms and 4.5 ms.
// - A write in progress at reset runs to completion.
// - During erase or page write the read-while-write busy flag stays set until reenabled or until a core reset.
// - EEPROM write in progress blocks fuse reads and the arming of flash self-programming; a store already armed still starts.
`include "fls_params.svh"
module fls_readout (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_por_n,
    input  wire logic        i_ctrl_wr,
    input  wire logic [7:0]  i_ctrl_wdata,
    input  wire logic        i_load,
    input  wire logic        i_store,
    input  wire logic [15:0] i_pointer,
    input  wire logic [7:0]  i_flash_rdata,
    input  wire logic        i_eeprom_write_enable_flag,
    input  wire logic [7:0]  i_lock_bits,
    input  wire logic [7:0]  i_fuse_low_byte,
    input  wire logic [7:0]  i_fuse_high_byte,
    input  wire logic [7:0]  i_fuse_extended_byte,
    input  wire logic [7:0]  i_sig_byte_0,
    input  wire logic [7:0]  i_sig_byte_1,
    input  wire logic [7:0]  i_sig_byte_2,
    input  wire logic [7:0]  i_osc_cal_byte,
    output logic [7:0]       o_load_data,
    output logic             o_load_valid,
    output logic [7:0]       o_self_prog_control_reg,
    output logic             o_rww_busy_flag,
    output logic             o_flash_write_busy
);
    import fls_pkg::*;

    // ----------------------------------------------------------------
    // Control bit positions
    // ----------------------------------------------------------------
    localparam int ENABLE_BIT = 0;
    localparam int ERASE_BIT  = 1;
    localparam int WRITE_BIT  = 2;
    localparam int LOCKSET_BIT = 3;
    localparam int REENABLE_BIT = 4;
    localparam int SIGNATURE_READ_BIT_BIT  = 5;
    localparam int BUSY_BIT   = 6;

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic       rst_meta_q;
    logic       rst_sync_q;
    logic       ee_meta_q;
    logic       ee_sync_q;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ee_meta_q <= 1'b0;
            ee_sync_q <= 1'b0;
        end else begin
            ee_meta_q <= i_eeprom_write_enable_flag;
            ee_sync_q <= ee_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Arming state and window counter
    // ----------------------------------------------------------------
    fls_arm_e   arm_q;
    logic [2:0] win_q;
    logic       spm_arm_q;
    logic       rww_busy_q;
    logic       wr_busy;
    logic       wr_start;
    fls_op_e    op;

    // Control writes are ignored while an EEPROM write or flash write runs
    wire ctrl_ok = i_ctrl_wr && !ee_sync_q && !wr_busy;
    wire armed_read = (arm_q != FLS_ARM_NONE);
    wire in_load_win = armed_read && (win_q < 3'(`FLS_LOAD_WINDOW));
    wire take_read = i_load && in_load_win && !ee_sync_q;

    always_comb begin
        op = FLS_OP_NONE;
        if (spm_arm_q && i_store && win_q < 3'(`FLS_STORE_WINDOW)) begin
            if (arm_q == FLS_ARM_LOCK) begin
                op = FLS_OP_LOCK_WRITE;
            end else if (o_self_prog_control_reg[ERASE_BIT]) begin
                op = FLS_OP_ERASE;
            end else if (o_self_prog_control_reg[WRITE_BIT]) begin
                op = FLS_OP_PAGE_WRITE;
            end
        end
    end

    assign wr_start = (op != FLS_OP_NONE);

    // Counter restarts on the arming write, so cycle 0 is the next clock
    always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            arm_q     <= FLS_ARM_NONE;
            spm_arm_q <= 1'b0;
            win_q     <= 3'h0;
        end else if (ctrl_ok && i_ctrl_wdata[ENABLE_BIT]) begin
            win_q     <= 3'h0;
            spm_arm_q <= 1'b1;
            if (i_ctrl_wdata[SIGNATURE_READ_BIT_BIT]) begin
                arm_q <= FLS_ARM_SIG;
            end else if (i_ctrl_wdata[LOCKSET_BIT]) begin
                arm_q <= FLS_ARM_LOCK;
            end else begin
                arm_q <= FLS_ARM_NONE;
            end
        end else if (take_read || wr_start) begin
            arm_q     <= FLS_ARM_NONE;
            spm_arm_q <= 1'b0;
        end else if (spm_arm_q) begin
            win_q <= win_q + 3'h1;
            // Lock-set stays armed for a store up to four cycles; sig only three
            if (arm_q == FLS_ARM_SIG && win_q == 3'(`FLS_LOAD_WINDOW - 1)) begin
                arm_q     <= FLS_ARM_NONE;
                spm_arm_q <= 1'b0;
            end else if (win_q == 3'(`FLS_STORE_WINDOW - 1)) begin
                arm_q     <= FLS_ARM_NONE;
                spm_arm_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read-back selection
    // ----------------------------------------------------------------
    function automatic logic [7:0] lock_fuse_sel(input logic [15:0] ptr);
        // Stored bits keep 0 as programmed, so no inversion is applied
        case (ptr)
            `FLS_ADDR_LOCK:      lock_fuse_sel = i_lock_bits | `FLS_LOCK_UNDEF_MASK;
            `FLS_ADDR_FUSE_LOW:  lock_fuse_sel = i_fuse_low_byte;
            `FLS_ADDR_FUSE_HIGH: lock_fuse_sel = i_fuse_high_byte;
            `FLS_ADDR_FUSE_EXT:  lock_fuse_sel = i_fuse_extended_byte | `FLS_EXT_UNDEF_MASK;
            default:             lock_fuse_sel = 8'hFF;
        endcase
    endfunction : lock_fuse_sel

    function automatic logic [7:0] sig_sel(input logic [15:0] ptr);
        // Reserved addresses read all ones; software must avoid them
        case (ptr)
            `FLS_ADDR_SIG_0: sig_sel = i_sig_byte_0;
            `FLS_ADDR_CAL:   sig_sel = i_osc_cal_byte;
            `FLS_ADDR_SIG_1: sig_sel = i_sig_byte_1;
            `FLS_ADDR_SIG_2: sig_sel = i_sig_byte_2;
            default:         sig_sel = 8'hFF;
        endcase
    endfunction : sig_sel

    always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            o_load_data  <= 8'h00;
            o_load_valid <= 1'b0;
        end else begin
            o_load_valid <= i_load;
            if (take_read && arm_q == FLS_ARM_LOCK) begin
                o_load_data <= lock_fuse_sel(i_pointer);
            end else if (take_read && arm_q == FLS_ARM_SIG) begin
                o_load_data <= sig_sel(i_pointer);
            end else if (i_load) begin
                o_load_data <= i_flash_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Flash write timing and read-while-write busy
    // ----------------------------------------------------------------
    fls_write_timer u_timer (
        .i_core_clk (i_core_clk),
        .i_por_n    (i_por_n),
        .i_start    (wr_start),
        .o_busy     (wr_busy)
    );

    always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rww_busy_q <= 1'b0;
        end else if (op == FLS_OP_ERASE || op == FLS_OP_PAGE_WRITE) begin
            rww_busy_q <= 1'b1;
        end else if (ctrl_ok && i_ctrl_wdata[REENABLE_BIT] && i_ctrl_wdata[ENABLE_BIT]) begin
            rww_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            o_rww_busy_flag         <= 1'b0;
            o_flash_write_busy      <= 1'b0;
            o_self_prog_control_reg <= 8'h00;
        end else begin
            o_rww_busy_flag    <= rww_busy_q;
            o_flash_write_busy <= wr_busy;
            if (ctrl_ok) begin
                o_self_prog_control_reg <= i_ctrl_wdata & 8'h3F;
            end else if (!spm_arm_q && !wr_busy) begin
                o_self_prog_control_reg <= 8'h00;
            end
            o_self_prog_control_reg[BUSY_BIT] <= rww_busy_q;
        end
    end
endmodule : fls_readout

// file: dv/fls_readout_props.sv
// Port-level assertions for the fuse, lock and signature readout block
module fls_readout_props (
    input wire logic        i_core_clk,
    input wire logic        i_reset_n,
    input wire logic        i_ctrl_wr,
    input wire logic [7:0]  i_ctrl_wdata,
    input wire logic        i_load,
    input wire logic        i_store,
    input wire logic [15:0] i_pointer,
    input wire logic [7:0]  i_flash_rdata,
    input wire logic        i_eeprom_write_enable_flag,
    input wire logic [7:0]  i_lock_bits,
    input wire logic [7:0]  i_fuse_low_byte,
    input wire logic [7:0]  i_fuse_high_byte,
    input wire logic [7:0]  i_fuse_extended_byte,
    input wire logic [7:0]  i_sig_byte_0,
    input wire logic [7:0]  i_sig_byte_1,
    input wire logic [7:0]  i_sig_byte_2,
    input wire logic [7:0]  i_osc_cal_byte,
    input wire logic [7:0]  o_load_data,
    input wire logic        o_load_valid,
    input wire logic [7:0]  o_self_prog_control_reg,
    input wire logic        o_rww_busy_flag,
    input wire logic        o_flash_write_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    logic [4:0] wr_q;
    logic [2:0] ee_q;
    always_ff @(posedge i_core_clk) begin
        wr_q <= {wr_q[3:0], i_ctrl_wr};
        ee_q <= {ee_q[1:0], i_eeprom_write_enable_flag};
    end
    // Arming only counts once the EEPROM flag has been low through its synchroniser
    property p_rd(logic [7:0] cmd, logic [15:0] ptr, logic [7:0] exp);
        i_ctrl_wr && i_ctrl_wdata == cmd && !o_flash_write_busy && ee_q == 3'h0
            ##1 i_load && i_pointer == ptr |=> o_load_data == exp;
    endproperty
    AST_LOCK: assert property (p_rd(8'h09, 16'h0001, i_lock_bits | 8'hC0)) else $error("bad lock");
    AST_FLOW: assert property (p_rd(8'h09, 16'h0000, i_fuse_low_byte)) else $error("bad fuse low");
    AST_FEXT: assert property (p_rd(8'h09, 16'h0002, i_fuse_extended_byte | 8'hF8)) else $error("bad ext");
    AST_FHIGH: assert property (p_rd(8'h09, 16'h0003, i_fuse_high_byte)) else $error("bad fuse high");
    AST_SIG2: assert property (p_rd(8'h21, 16'h0004, i_sig_byte_2)) else $error("bad sig2");
    // Busy for the read-while-write region appears two edges after an accepted store
    AST_RWW_RISE: assert property ($rose(o_rww_busy_flag) |-> $past(i_store, 2)) else $error("rww busy without store");
    AST_SIG0: assert property (p_rd(8'h21, 16'h0000, i_sig_byte_0)) else $error("bad sig0");
    AST_SIG1: assert property (p_rd(8'h21, 16'h0002, i_sig_byte_1)) else $error("bad sig1");
    AST_CAL: assert property (p_rd(8'h21, 16'h0001, i_osc_cal_byte)) else $error("bad cal");
    AST_ANSWER: assert property (o_load_valid == $past(i_load)) else $error("bad valid");
    AST_PLAIN: assert property (i_load && !i_ctrl_wr && wr_q == 5'h00 |=>
        o_load_data == $past(i_flash_rdata)) else $error("plain load wrong");
    AST_LATE: assert property (i_ctrl_wr ##1 !(i_load || i_ctrl_wr) [*3] ##1 i_load && !i_ctrl_wr |=>
        o_load_data == $past(i_flash_rdata)) else $error("late load wrong");
    AST_SIG_EXP: assert property (i_ctrl_wr && i_ctrl_wdata == 8'h21 ##1 !(i_load || i_ctrl_wr) [*3]
        |-> ##[1:2] o_self_prog_control_reg[5:0] == 6'h00) else $error("sig arm stuck");
    AST_LOCK_EXP: assert property (i_ctrl_wr && i_ctrl_wdata == 8'h09 ##1 !(i_load || i_store || i_ctrl_wr) [*4]
        |-> ##[1:2] o_self_prog_control_reg[5:0] == 6'h00) else $error("lock arm stuck");
    C_LOCK: cover property (i_ctrl_wr && i_ctrl_wdata == 8'h09 ##1 i_load);
    C_SIG: cover property (i_ctrl_wr && i_ctrl_wdata == 8'h21 ##1 i_load);
    C_LATE: cover property (i_ctrl_wr ##1 !i_load [*3] ##1 i_load);
    C_ERASE: cover property ($rose(o_rww_busy_flag));
endmodule : fls_readout_props

// file: dv/fls_cpu_model.sv
// Behavioural CPU core that arms the control register and issues loads
module fls_cpu_model (
    input  wire logic        i_core_clk,
    input  wire logic [7:0]  i_load_data,
    input  wire logic        i_load_valid,
    input  wire logic [7:0]  i_ctrl_reg,
    output logic             o_ctrl_wr,
    output logic [7:0]       o_ctrl_wdata,
    output logic             o_load,
    output logic             o_store,
    output logic [15:0]      o_pointer,
    output logic [7:0]       o_flash_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {o_ctrl_wr, o_ctrl_wdata, o_load, o_store, o_pointer} = '0;
    // Flash stand-in differs per address so a wrong source is visible
    assign o_flash_rdata = o_pointer[7:0] ^ 8'hA5;
    task automatic rd(input logic [7:0] cmd, input logic [15:0] ptr, input int gap,
                      output logic [7:0] data, output logic vld);
        for (int n = 0; n < 20 && i_ctrl_reg[0] !== 1'b0; n++) @(posedge i_core_clk);
        @(posedge i_core_clk);
        o_ctrl_wr <= 1'b1;
        o_ctrl_wdata <= cmd;
        o_pointer <= ptr;
        @(posedge i_core_clk);
        o_ctrl_wr <= 1'b0;
        repeat (gap - 1) @(posedge i_core_clk);
        o_load <= 1'b1;
        @(posedge i_core_clk);
        o_load <= 1'b0;
        #1;
        data = i_load_data;
        vld = i_load_valid;
    endtask : rd
    // Arms the control register, then issues a store-program instruction gap cycles later
    task automatic st(input logic [7:0] cmd, input int gap);
        for (int n = 0; n < 20 && i_ctrl_reg[0] !== 1'b0; n++) @(posedge i_core_clk);
        @(posedge i_core_clk);
        o_ctrl_wr <= 1'b1;
        o_ctrl_wdata <= cmd;
        @(posedge i_core_clk);
        o_ctrl_wr <= 1'b0;
        repeat (gap - 1) @(posedge i_core_clk);
        o_store <= 1'b1;
        @(posedge i_core_clk);
        o_store <= 1'b0;
    endtask : st
endmodule : fls_cpu_model

// file: dv/testbench.sv
// Self-checking bench for the fuse, lock and signature readout block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk = 1'b0, i_reset_n = 1'b0, i_por_n = 1'b0, i_eeprom_write_enable_flag = 1'b0;
    logic        i_ctrl_wr, i_load, i_store, o_load_valid, o_rww_busy_flag, o_flash_write_busy;
    logic [7:0]  i_ctrl_wdata, i_flash_rdata, o_load_data, o_self_prog_control_reg, d;
    logic [15:0] i_pointer;
    logic [7:0]  i_lock_bits, i_fuse_low_byte, i_fuse_high_byte, i_fuse_extended_byte;
    logic [7:0]  i_sig_byte_0, i_sig_byte_1, i_sig_byte_2, i_osc_cal_byte;
    logic        v;
    int          err_count = 0, check_count = 0, cyc = 0;
    // Flash write limits in 40 ns clock cycles
    localparam int MIN_CYC = 3700 * 1000 / 40;
    localparam int MAX_CYC = 4500 * 1000 / 40;
    always #20 i_core_clk = ~i_core_clk;
    fls_readout i_dut (.*);
    fls_cpu_model i_cpu (.i_core_clk(i_core_clk), .i_load_data(o_load_data), .i_load_valid(o_load_valid),
        .i_ctrl_reg(o_self_prog_control_reg), .o_ctrl_wr(i_ctrl_wr), .o_ctrl_wdata(i_ctrl_wdata),
        .o_load(i_load), .o_store(i_store), .o_pointer(i_pointer), .o_flash_rdata(i_flash_rdata));
    function automatic logic [7:0] exp_byte(input logic [7:0] cmd, input logic [15:0] p);
        case ({cmd[5], p[2:0]})
            4'h0: return i_fuse_low_byte;
            4'h1: return i_lock_bits | 8'hC0;
            4'h2: return i_fuse_extended_byte | 8'hF8;
            4'h3: return i_fuse_high_byte;
            4'h8: return i_sig_byte_0;
            4'h9: return i_osc_cal_byte;
            4'hA: return i_sig_byte_1;
            default: return i_sig_byte_2;
        endcase
    endfunction : exp_byte
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    task automatic do_reset;
        i_reset_n <= 1'b0;
        repeat (5) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        i_por_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
    endtask : do_reset
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 99000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        logic [15:0] p;
        int          t0;
        {i_lock_bits, i_fuse_low_byte, i_fuse_high_byte, i_fuse_extended_byte} = '0;
        {i_sig_byte_0, i_sig_byte_1, i_sig_byte_2, i_osc_cal_byte} = '0;
        void'($urandom(29));
        do_reset();
        for (int r = 0; r < 6; r++) begin
            @(posedge i_core_clk);
            {i_lock_bits, i_fuse_low_byte, i_fuse_high_byte, i_fuse_extended_byte, i_sig_byte_0,
             i_sig_byte_1, i_sig_byte_2, i_osc_cal_byte} <= (r == 0) ? 64'h0 : (r == 1) ? {64{1'b1}}
                : {$urandom, $urandom};
            for (int k = 0; k < 8; k++) begin
                p = (k == 7) ? 16'h0004 : 16'(k % 4);
                i_cpu.rd((k < 4) ? 8'h09 : 8'h21, p, 1 + ($urandom % 3), d, v);
                check(d, exp_byte((k < 4) ? 8'h09 : 8'h21, p));
                check({7'h00, v}, 8'h01);
            end
        end
        $display("armed reads done");
        for (int k = 0; k < 3; k++) begin
            i_cpu.rd((k == 1) ? 8'h21 : 8'h09, 16'h0001, (k == 2) ? 5 : 4, d, v);
            check(d, 8'hA4);
            repeat (3) @(posedge i_core_clk);
            check(o_self_prog_control_reg & 8'h3F, 8'h00);
            i_cpu.rd(8'h00, 16'h0002, 2, d, v);
            check(d, 8'hA7);
        end
        $display("expiry done");
        i_eeprom_write_enable_flag <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_cpu.rd(8'h09, 16'h0001, 1, d, v);
        check(d, 8'hA4);
        check(o_self_prog_control_reg & 8'h3F, 8'h00);
        i_eeprom_write_enable_flag <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        $display("eeprom block done");
        // Page erase: one long write, interrupted by a core reset
        i_cpu.st(8'h03, 1);
        @(negedge i_core_clk);
        t0 = cyc;
        repeat (2) @(negedge i_core_clk);
        check({6'h00, o_rww_busy_flag, o_flash_write_busy}, 8'h03);
        check(o_self_prog_control_reg, 8'h43);
        do_reset();
        @(negedge i_core_clk);
        check({7'h00, o_flash_write_busy}, 8'h01);
        while (o_flash_write_busy !== 1'b0 && cyc < 99000) @(negedge i_core_clk);
        check({7'h00, ((cyc - t0 - 1) >= MIN_CYC) && ((cyc - t0 - 1) <= MAX_CYC)}, 8'h01);
        $display("flash write done");
        i_cpu.rd(8'h21, 16'h0001, 3, d, v);
        check(d, i_osc_cal_byte);
        $display("mid-run reset done");
        conclude();
    end
endmodule : testbench
bind fls_readout fls_readout_props i_props (.*);
